// ---- hw/timer_defs.vh ----
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

`define ADDR_CTRL0    4'h0
`define ADDR_CTRL1    4'h1
`define ADDR_CTRL2    4'h2
`define ADDR_CNT_LO   4'h3
`define ADDR_CNT_HI   4'h4
`define ADDR_CMPA_LO  4'h5
`define ADDR_CMPA_HI  4'h6
`define ADDR_CMPB_LO  4'h7
`define ADDR_CMPB_HI  4'h8
`define ADDR_FLAGS    4'h9

`define CTRL_RESET    8'h00

// control 0 fields
`define C0_PAUSE      7
`define C0_CKSEL_HI   6
`define C0_CKSEL_LO   4
`define C0_ON         3
`define C0_PER_HI     2
`define C0_PER_LO     0

// control 1 / control 2 fields (same layout for both channels)
`define C1_MODE_HI    7
`define C1_MODE_LO    6
`define C1_FUNC_HI    5
`define C1_FUNC_LO    4
`define C1_OUTCTL     3
`define C1_POL        2
`define C1_DIR        1
`define C1_CCLR       0

// flag register bits
`define FL_A          0
`define FL_B          1
`define FL_P          2

`define MODE_CMP      2'h0
`define MODE_CAP      2'h1
`define MODE_PWM      2'h2
`define MODE_TMR      2'h3

`define CK_SYS4       3'h0
`define CK_SYS        3'h1
`define CK_H16        3'h2
`define CK_H64        3'h3
`define CK_TBC        3'h4
`define CK_UNDEF      3'h5
`define CK_PIN_RISE   3'h6
`define CK_PIN_FALL   3'h7

`define DIV_SYS4      4
`define DIV_H16       16
`define DIV_H64       64

`endif

// ---- hw/enhanced_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.vh"

module enhanced_timer #(
  parameter CNT_W = 10
) (
  input  wire             clk_sys_in,
  input  wire             nrst_in,
  input  wire [3:0]       addr_in,
  input  wire [7:0]       wdata_in,
  input  wire             wr_in,
  input  wire             rd_in,
  output reg  [7:0]       rdata_out,
  input  wire             external_timer_clock_pin_in,
  input  wire             time_base_clock_in,
  input  wire             channel_a_pin_in,
  output reg              channel_a_pin_out,
  output reg              channel_a_pin_oe_out,
  output reg              channel_b_pin0_out,
  output reg              channel_b_pin0_oe_out
);

  reg  [7:0]       ctrl0_reg;
  reg  [7:0]       ctrl1_reg;
  reg  [7:0]       ctrl2_reg;
  reg  [CNT_W-1:0] cnt_reg;
  reg  [CNT_W-1:0] cmp_a_reg;
  reg  [CNT_W-1:0] cmp_b_reg;
  reg  [2:0]       flags_reg;
  reg              on_prev_reg;
  reg  [5:0]       div_reg;
  reg  [2:0]       ext_sync_reg;
  reg  [2:0]       tbc_sync_reg;
  reg  [2:0]       cap_sync_reg;
  reg              a_lvl_reg;
  reg              b_lvl_reg;

  wire       pause        = ctrl0_reg[`C0_PAUSE];
  wire [2:0] clock_select_field = ctrl0_reg[`C0_CKSEL_HI:`C0_CKSEL_LO];
  wire       counter_on_bit = ctrl0_reg[`C0_ON];
  wire [2:0] period_field = ctrl0_reg[`C0_PER_HI:`C0_PER_LO];
  wire [1:0] a_mode       = ctrl1_reg[`C1_MODE_HI:`C1_MODE_LO];
  wire [1:0] a_func       = ctrl1_reg[`C1_FUNC_HI:`C1_FUNC_LO];
  wire       a_outctl     = ctrl1_reg[`C1_OUTCTL];
  wire       a_pol        = ctrl1_reg[`C1_POL];
  wire       counter_clear_select = ctrl1_reg[`C1_CCLR];
  wire [1:0] b_mode       = ctrl2_reg[`C1_MODE_HI:`C1_MODE_LO];
  wire [1:0] b_func       = ctrl2_reg[`C1_FUNC_HI:`C1_FUNC_LO];
  wire       b_outctl     = ctrl2_reg[`C1_OUTCTL];
  wire       b_pol        = ctrl2_reg[`C1_POL];

  // counter only counts up in this build
  wire       direction_flag = 1'b0;

  // pure write decode, reused for every writable register
  function wr_hit;
    input [3:0] a;
    input [3:0] target;
    input       w;
    begin
      wr_hit = w && (a == target);
    end
  endfunction

  // next output level for compare action on a match
  function cmp_action;
    input [1:0] func;
    input       cur;
    begin
      case (func)
        2'h0:    cmp_action = cur;
        2'h1:    cmp_action = 1'b0;
        2'h2:    cmp_action = 1'b1;
        default: cmp_action = ~cur;
      endcase
    end
  endfunction

  // internal clock enables; high clock taken as the system clock here
  wire sys4_en = (div_reg[1:0] == 2'h3);
  wire h16_en  = (div_reg[3:0] == 4'hF);
  wire h64_en  = (div_reg == 6'h3F);
  // second flop onward only; the first stage is never looked at
  wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
  wire ext_fall = ~ext_sync_reg[1] & ext_sync_reg[2];
  wire tbc_rise = tbc_sync_reg[1] & ~tbc_sync_reg[2];
  wire cap_rise = cap_sync_reg[1] & ~cap_sync_reg[2];
  wire cap_fall = ~cap_sync_reg[1] & cap_sync_reg[2];

  reg clk_sel_en;
  always @*
  begin
    case (clock_select_field)
      `CK_SYS4:     clk_sel_en = sys4_en;
      `CK_SYS:      clk_sel_en = 1'b1;
      `CK_H16:      clk_sel_en = h16_en;
      `CK_H64:      clk_sel_en = h64_en;
      `CK_TBC:      clk_sel_en = tbc_rise;
      `CK_PIN_RISE: clk_sel_en = ext_rise;
      `CK_PIN_FALL: clk_sel_en = ext_fall;
      default:      clk_sel_en = 1'b0;
    endcase
  end

  wire on_rise = counter_on_bit & ~on_prev_reg;
  wire tick    = counter_on_bit & ~pause & clk_sel_en & ~on_rise;
  wire [CNT_W-1:0] cnt_inc = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};

  // compare matches are judged on the value being left, the period match on the value entered, so a nonzero period p gives p*128
  wire match_a   = tick && (cnt_reg == cmp_a_reg);
  wire match_b   = tick && (cnt_reg == cmp_b_reg);
  wire overflow  = tick && (cnt_reg == {CNT_W{1'b1}});
  wire match_p   = tick && ((period_field == 3'h0) ? overflow
                   : (cnt_inc[CNT_W-1:CNT_W-3] == period_field));
  wire single    = (a_mode == `MODE_PWM) && (a_func == 2'h3);
  wire capture   = (a_mode == `MODE_CAP);
  // capture ignores the clear select and always clears on period match
  wire clr_by_a  = counter_clear_select && !capture && (a_mode != `MODE_PWM);
  wire clr_hit   = clr_by_a ? match_a : match_p;
  wire flag_p_ev = match_p && !clr_by_a;

  reg cap_ev;
  always @*
  begin
    case (a_func)
      2'h0:    cap_ev = cap_rise;
      2'h1:    cap_ev = cap_fall;
      2'h2:    cap_ev = cap_rise | cap_fall;
      default: cap_ev = 1'b0;
    endcase
    cap_ev = cap_ev & capture & counter_on_bit;
  end

  wire flag_a_ev = capture ? cap_ev : match_a;
  wire [2:0] flag_set;
  assign flag_set[`FL_A] = flag_a_ev;
  assign flag_set[`FL_B] = match_b;
  assign flag_set[`FL_P] = flag_p_ev;

  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      div_reg      <= 6'h00;
      ext_sync_reg <= 3'h0;
      tbc_sync_reg <= 3'h0;
      cap_sync_reg <= 3'h0;
      on_prev_reg  <= 1'b0;
    end
    else
    begin
      div_reg      <= div_reg + 6'h01;
      ext_sync_reg <= {ext_sync_reg[1:0], external_timer_clock_pin_in};
      tbc_sync_reg <= {tbc_sync_reg[1:0], time_base_clock_in};
      cap_sync_reg <= {cap_sync_reg[1:0], channel_a_pin_in};
      on_prev_reg  <= counter_on_bit;
    end
  end

  // register writes and hardware updates
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl0_reg <= `CTRL_RESET;
      ctrl1_reg <= `CTRL_RESET;
      ctrl2_reg <= `CTRL_RESET;
      cmp_a_reg <= {CNT_W{1'b0}};
      cmp_b_reg <= {CNT_W{1'b0}};
      flags_reg <= 3'h0;
    end
    else
    begin
      if (wr_hit(addr_in, `ADDR_CTRL0, wr_in))
        ctrl0_reg <= wdata_in;
      else if (single && match_a)
        ctrl0_reg[`C0_ON] <= 1'b0;
      if (wr_hit(addr_in, `ADDR_CTRL1, wr_in))
        ctrl1_reg <= {wdata_in[7:2], 1'b0, wdata_in[0]};
      if (wr_hit(addr_in, `ADDR_CTRL2, wr_in))
        ctrl2_reg <= {wdata_in[7:2], 1'b0, wdata_in[0]};
      if (wr_hit(addr_in, `ADDR_CMPA_LO, wr_in))
        cmp_a_reg[7:0] <= wdata_in;
      if (wr_hit(addr_in, `ADDR_CMPA_HI, wr_in))
        cmp_a_reg[CNT_W-1:8] <= wdata_in[CNT_W-9:0];
      if (cap_ev)
        cmp_a_reg <= cnt_reg;
      if (wr_hit(addr_in, `ADDR_CMPB_LO, wr_in))
        cmp_b_reg[7:0] <= wdata_in;
      if (wr_hit(addr_in, `ADDR_CMPB_HI, wr_in))
        cmp_b_reg[CNT_W-1:8] <= wdata_in[CNT_W-9:0];
      // write one to clear; a new event in the same cycle wins
      if (wr_hit(addr_in, `ADDR_FLAGS, wr_in))
        flags_reg <= (flags_reg & ~wdata_in[2:0]) | flag_set;
      else
        flags_reg <= flags_reg | flag_set;
    end
  end

  // counter
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cnt_reg <= {CNT_W{1'b0}};
    else if (on_rise)
      cnt_reg <= {CNT_W{1'b0}};
    else if (tick)
    begin
      if (clr_hit && !single)
        cnt_reg <= {CNT_W{1'b0}};
      else
        cnt_reg <= cnt_inc;
    end
  end

  // channel levels before polarity
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      a_lvl_reg <= 1'b0;
      b_lvl_reg <= 1'b0;
    end
    else
    begin
      if (on_rise)
        a_lvl_reg <= a_outctl;
      else if (match_a)
        a_lvl_reg <= cmp_action(a_func, a_lvl_reg);
      if (on_rise)
        b_lvl_reg <= b_outctl;
      else if (match_b)
        b_lvl_reg <= cmp_action(b_func, b_lvl_reg);
    end
  end

  // PWM duty from compare A, period from the period comparator
  reg a_pin_next;
  always @*
  begin
    case (a_mode)
      `MODE_CMP: a_pin_next = a_lvl_reg;
      `MODE_PWM:
      begin
        case (a_func)
          2'h0:    a_pin_next = ~a_outctl;
          2'h1:    a_pin_next = a_outctl;
          2'h2:    a_pin_next = (cnt_reg < cmp_a_reg) ? a_outctl : ~a_outctl;
          default: a_pin_next = counter_on_bit ? a_outctl : ~a_outctl;
        endcase
      end
      default:   a_pin_next = 1'b0;
    endcase
  end

  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      channel_a_pin_out     <= 1'b0;
      channel_a_pin_oe_out  <= 1'b0;
      channel_b_pin0_out    <= 1'b0;
      channel_b_pin0_oe_out <= 1'b0;
    end
    else
    begin
      channel_a_pin_out     <= a_pin_next ^ a_pol;
      // no drive in capture or timer/counter mode
      channel_a_pin_oe_out  <= (a_mode == `MODE_CMP) ||
                               (a_mode == `MODE_PWM);
      channel_b_pin0_out    <= b_lvl_reg ^ b_pol;
      channel_b_pin0_oe_out <= (b_mode == `MODE_CMP);
    end
  end

  // read port, data valid the cycle after the strobe
  reg [7:0] rd_mux;
  always @*
  begin
    case (addr_in)
      `ADDR_CTRL0:   rd_mux = ctrl0_reg;
      `ADDR_CTRL1:   rd_mux = {ctrl1_reg[7:2], direction_flag,
                               ctrl1_reg[0]};
      `ADDR_CTRL2:   rd_mux = ctrl2_reg;
      `ADDR_CNT_LO:  rd_mux = cnt_reg[7:0];
      `ADDR_CNT_HI:  rd_mux = {6'h00, cnt_reg[CNT_W-1:8]};
      `ADDR_CMPA_LO: rd_mux = cmp_a_reg[7:0];
      `ADDR_CMPA_HI: rd_mux = {6'h00, cmp_a_reg[CNT_W-1:8]};
      `ADDR_CMPB_LO: rd_mux = cmp_b_reg[7:0];
      `ADDR_CMPB_HI: rd_mux = {6'h00, cmp_b_reg[CNT_W-1:8]};
      `ADDR_FLAGS:   rd_mux = {5'h00, flags_reg};
      default:       rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_out <= 8'h00;
    else if (rd_in)
      rdata_out <= rd_mux;
    else
      rdata_out <= 8'h00;
  end

endmodule // enhanced_timer

`default_nettype wire

// ---- verification/timer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_sva (
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       channel_a_pin_out,
  input wire logic       channel_a_pin_oe_out,
  input wire logic       channel_b_pin0_oe_out
);
  // shadows of software writes; a_ok drops once a capture may overwrite
  logic [7:0] c0_reg, c1_reg, c2_reg, a_reg;
  logic       a_ok_reg;
  always @(posedge clk_sys_in or negedge nrst_in)
    if (!nrst_in)
    begin
      {c0_reg, c1_reg, c2_reg, a_reg, a_ok_reg} <= 33'h0;
    end
    else
    begin
      if (wr_in && addr_in == 4'h0) c0_reg <= wdata_in;
      if (wr_in && addr_in == 4'h1) c1_reg <= wdata_in;
      if (wr_in && addr_in == 4'h2) c2_reg <= wdata_in;
      if (wr_in && addr_in == 4'h5) a_reg <= wdata_in;
      if (wr_in && addr_in == 4'h5) a_ok_reg <= 1'b1;
      if (c1_reg[7:6] == 2'h1) a_ok_reg <= 1'b0;
    end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  AST_HI_ZERO: assert property ($past(rd_in) && $past(addr_in) inside
    {4'h4, 4'h6, 4'h8} |-> rdata_out[7:2] == 6'h00)
    else $error("high byte upper bits not zero");
  AST_UNMAPPED: assert property ($past(rd_in) && $past(addr_in) > 4'h9
    |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_CTRL1_RB: assert property ($past(rd_in) && $past(addr_in) == 4'h1
    |-> rdata_out == ($past(c1_reg) & 8'hFD))
    else $error("control 1 readback wrong");
  AST_CMPA_RB: assert property ($past(rd_in) && $past(addr_in) == 4'h5
    && $past(a_ok_reg) |-> rdata_out == $past(a_reg))
    else $error("compare A readback wrong");
  AST_OE_A: assert property (c1_reg[6] && $past(c1_reg[6])
    |-> !channel_a_pin_oe_out)
    else $error("channel A driven in capture or timer mode");
  AST_OE_B: assert property (c2_reg[7:6] != 2'h0
    && $past(c2_reg[7:6]) != 2'h0 |-> !channel_b_pin0_oe_out)
    else $error("channel B driven outside compare mode");
  AST_CMP_INIT: assert property ($rose(c0_reg[3]) && c1_reg[7:6] == 2'h0
    && a_reg > 8'h02 |-> ##[1:2] channel_a_pin_out == (c1_reg[3] ^ c1_reg[2]))
    else $error("compare pin not at initial level");
endmodule // timer_sva
bind enhanced_timer timer_sva chk (.clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .channel_a_pin_out(channel_a_pin_out),
  .channel_a_pin_oe_out(channel_a_pin_oe_out),
  .channel_b_pin0_oe_out(channel_b_pin0_oe_out));
`default_nettype wire

// ---- verification/pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic clk_sys_in,
  output wire logic ext_clk_out,
  output wire logic tbc_out,
  output wire logic cap_out
);
  logic [2:0] lvl_reg = 3'h0;
  assign ext_clk_out = lvl_reg[0];
  assign tbc_out     = lvl_reg[1];
  assign cap_out     = lvl_reg[2];
  // wide spacing so the two-stage synchroniser sees every level
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_sys_in);
      lvl_reg[which] <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      lvl_reg[which] <= 1'b0;
    end
  endtask
endmodule // pin_model
`default_nettype wire

// ---- verification/tb_enhanced_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_enhanced_timer;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic [3:0]  addr_in    = 4'h0;
  logic [7:0]  wdata_in   = 8'h00;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic [31:0] seed       = 32'h9982EDEA;
  logic [7:0]  r;
  logic [1:0]  f;
  wire  [7:0]  rdata_out;
  wire         ext_pin, tbc_pin, cap_pin, a_out, a_oe, b_out, b_oe;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          cycles     = 0;
  int          i;
  always #25 clk_sys_in = ~clk_sys_in;
  enhanced_timer dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .external_timer_clock_pin_in(ext_pin),
    .time_base_clock_in(tbc_pin), .channel_a_pin_in(cap_pin),
    .channel_a_pin_out(a_out), .channel_a_pin_oe_out(a_oe),
    .channel_b_pin0_out(b_out), .channel_b_pin0_oe_out(b_oe));
  pin_model pins (.clk_sys_in(clk_sys_in), .ext_clk_out(ext_pin),
    .tbc_out(tbc_pin), .cap_out(cap_pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic cmp_pin(input logic [1:0] fn, input logic oc);
    // no change keeps the initial level, toggle flips it once
    return (fn == 2'h0) ? oc : (fn == 2'h3) ? ~oc : (fn == 2'h2);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, e);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 r = rdata_out;
    chk(r & m, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic pc(input int which, input int n, input logic [7:0] e);
    pins.pulse(which, n);
    wait_n(6);
    rc(4'h3, 8'hFF, e);
  endtask
  // the timer is always off while its mode changes
  task automatic prep(input logic [7:0] c1);
    wr(4'h0, 8'h00);
    wr(4'h1, c1);
    wr(4'h9, 8'h07);
  endtask
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles > 10000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    for (i = 0; i < 16; i++)
      rc(i[3:0], 8'hFF, 8'h00);
    $display("reset test done");
    for (i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      wr(4'h5, seed[7:0]);
      wr(4'h6, seed[15:8]);
      wr(4'h8, seed[31:24]);
      wr(4'h1, seed[23:16]);
      wr(4'h2, seed[31:24]);
      wr(4'h3, seed[15:8]);
      rc(4'h6, 8'hFF, {6'h00, seed[9:8]});
      rc(4'h5, 8'hFF, seed[7:0]);
      rc(4'h8, 8'hFF, {6'h00, seed[25:24]});
      rc(4'h1, 8'hFF, seed[23:16] & 8'hFD);
      rc(4'h3, 8'hFF, 8'h00);
    end
    $display("register test done");
    prep(8'hC0);
    for (i = 4; i < 8; i++)
    begin
      wr(4'h0, 8'h00);
      wr(4'h0, {1'b0, i[2:0], 4'h8});
      pc(i == 4, 5, (i == 5) ? 8'h00 : 8'h05);
    end
    wr(4'h0, 8'hF8);
    pc(0, 3, 8'h05);
    wr(4'h0, 8'h78);
    pc(0, 2, 8'h07);
    wr(4'h0, 8'h70);
    pc(0, 2, 8'h07);
    wr(4'h0, 8'h78);
    rc(4'h3, 8'hFF, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      wr(4'h0, 8'h00);
      wr(4'h0, {1'b0, i[2:0], 4'h8});
      wait_n(40);
      wr(4'h0, {1'b1, i[2:0], 4'h8});
      // 41 ticks at full rate; divider phase is free, so 10 or 11 at /4
      rc(4'h3, i ? 8'hFF : 8'hFE, i ? 8'h29 : 8'h0A);
      chk({7'h00, r > (i ? 8'h25 : 8'h08) && r < (i ? 8'h2E : 8'h0D)}, 8'h01);
    end
    $display("clock test done");
    prep(8'hC0);
    wr(4'h0, 8'h19);
    wait_n(100);
    rc(4'h9, 8'h04, 8'h00);
    wait_n(40);
    rc(4'h9, 8'h04, 8'h04);
    // 16 ticks after the wrap; an unwrapped count would have bit 7 set
    rc(4'h3, 8'h80, 8'h00);
    wr(4'h9, 8'h04);
    rc(4'h9, 8'h04, 8'h00);
    prep(8'hC0);
    wr(4'h0, 8'h18);
    wait_n(1000);
    rc(4'h9, 8'h04, 8'h00);
    wait_n(40);
    rc(4'h9, 8'hFF, 8'h07);
    $display("period test done");
    for (i = 0; i < 4; i++)
    begin
      prep({2'h1, i[1:0], 4'h0});
      wr(4'h6, 8'h03);
      wr(4'h0, 8'h18);
      pins.pulse(2, 1);
      wait_n(6);
      rc(4'h9, 8'h01, (i == 3) ? 8'h00 : 8'h01);
      rc(4'h6, 8'hFF, (i == 3) ? 8'h03 : 8'h00);
    end
    $display("capture test done");
    wr(4'h5, 8'h05);
    wr(4'h6, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      f = i[1:0];
      // toggle run clears by overflow, so only one match A in the window
      prep({2'h0, f, i[0], 2'h0, i != 3});
      wr(4'h0, 8'h18);
      wait_n(20);
      chk({6'h00, a_oe, a_out}, {7'h01, cmp_pin(f, i[0])});
    end
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h20);
    wr(4'h7, 8'h03);
    wr(4'h8, 8'h00);
    wr(4'h0, 8'h18);
    wait_n(2);
    chk({6'h00, b_oe, b_out}, 8'h02);
    wait_n(10);
    chk({6'h00, b_oe, b_out}, 8'h03);
    $display("compare test done");
    for (i = 0; i < 4; i++)
    begin
      prep({3'h4, i[0], 1'b1, i[1], 2'h0});
      wr(4'h0, 8'h18);
      wait_n(4);
      chk({7'h00, a_out}, {7'h00, i[0] ^ i[1]});
    end
    prep(8'hA8);
    wr(4'h0, 8'h18);
    wait_n(2);
    chk({7'h00, a_out}, 8'h01);
    wait_n(10);
    chk({7'h00, a_out}, 8'h00);
    prep(8'hB8);
    wr(4'h0, 8'h18);
    wait_n(2);
    chk({7'h00, a_out}, 8'h01);
    wait_n(15);
    rc(4'h0, 8'h08, 8'h00);
    chk({7'h00, a_out}, 8'h00);
    $display("pwm test done");
    give_verdict();
  end
endmodule // tb_enhanced_timer
`default_nettype wire
